// ==== sbt_pkg.sv ====
`default_nettype none
package sbt_pkg;

  // Widths
  localparam int IR_W   = 4;
  localparam int ID_W   = 32;
  localparam int SYNC_N = 2;

  // Opcodes
  localparam logic [3:0] OP_EXTEST   = 4'h0;
  localparam logic [3:0] OP_SAMPLE   = 4'h1;
  localparam logic [3:0] OP_IDENT    = 4'h2;
  localparam logic [3:0] OP_HIGHZ    = 4'h3;
  localparam logic [3:0] OP_CLAMP    = 4'h8;
  localparam logic [3:0] OP_VALIDATE = 4'hD;
  localparam logic [3:0] OP_BYPASS   = 4'hF;

  // Capture and reset values of the instruction register
  localparam logic [3:0] IR_CAPTURE_VAL = OP_VALIDATE;
  localparam logic [3:0] IR_RESET_VAL   = OP_IDENT;

  // Identity layout
  localparam int ID_REV_LSB = 28;
  localparam int ID_REV_W   = 4;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_DEV_W   = 16;
  localparam int ID_MFR_LSB = 1;
  localparam int ID_MFR_W   = 11;
  localparam logic ID_PRESENT_BIT = 1'b1;

  // Arbitrary neutral identity values
  localparam logic [3:0]  ID_REV_DEFAULT = 4'h1;
  localparam logic [15:0] ID_DEV_DEFAULT = 16'h0ABC;
  localparam logic [10:0] ID_MFR_DEFAULT = 11'h155;

  // Default depth of the snapshot buffer
  localparam int SNAP_DEPTH = 32;

  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h2,
    ST_CAP_DR  = 4'h3,
    ST_SH_DR   = 4'h4,
    ST_EX1_DR  = 4'h5,
    ST_PAU_DR  = 4'h6,
    ST_EX2_DR  = 4'h7,
    ST_UPD_DR  = 4'h8,
    ST_SEL_IR  = 4'h9,
    ST_CAP_IR  = 4'hA,
    ST_SH_IR   = 4'hB,
    ST_EX1_IR  = 4'hC,
    ST_PAU_IR  = 4'hD,
    ST_EX2_IR  = 4'hE,
    ST_UPD_IR  = 4'hF
  } sbt_state_t;

  typedef enum logic [1:0] {
    SEL_BYP  = 2'h0,
    SEL_CELL = 2'h1,
    SEL_ID   = 2'h2
  } sbt_sel_t;

endpackage : sbt_pkg
`default_nettype wire

// ==== sbt_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
    end
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; only counted words are read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule : sbt_fifo
`default_nettype wire

// ==== sbt_tap.sv ====
// Operation
// - EXTEST drives update cells onto outputs, boundary chain sits between TDI and TDO.
// - SAMPLE puts boundary chain in path, captures the latest core snapshot of input and output values.
// - SAMPLE shifts TDI data into the boundary cells for later preload.
// - Identity opcode loads the identity value and puts it in the serial path.
// - HIGHZ selects bypass and turns all functional output drivers off.
// - CLAMP holds boundary cell values on outputs, serial path through bypass.
// - Identity holds revision 31:28, device 27:12, manufacturer 11:1.
// - Identity bit 0 is always one.
// - Test logic resets itself at power-up; active-low test reset is optional.
// - Sampled inputs exclude the test data, mode select and reset pins.
// - Forced outputs cover every functional output but not test data out.
// - Capture-IR loads validate pattern 1101, low bits 01.
// - All-ones opcode shortens the serial path to the bypass bit.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap #(
  parameter int          N_IN       = 8,
  parameter int          N_OUT      = 8,
  parameter int          SNAP_DEPTH = sbt_pkg::SNAP_DEPTH,
  parameter logic [3:0]  ID_REV     = sbt_pkg::ID_REV_DEFAULT,
  parameter logic [15:0] ID_DEV     = sbt_pkg::ID_DEV_DEFAULT,
  parameter logic [10:0] ID_MFR     = sbt_pkg::ID_MFR_DEFAULT
) (
  // Core clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Test port
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  input  wire logic             trst_n,
  output logic                  tdo,
  output logic                  tdo_oe,
  // Functional input pins and their synchronised copy for the core
  input  wire logic [N_IN-1:0]  func_in_pin,
  output logic [N_IN-1:0]       func_in_sync,
  // Core output values and the pins they reach
  input  wire logic [N_OUT-1:0] core_out,
  input  wire logic             core_oe,
  output logic [N_OUT-1:0]      pin_out,
  output logic                  pin_oe,
  // Snapshot stream from the core
  input  wire logic             core_snap_valid,
  output logic                  core_snap_ready
);

  localparam int W = N_IN + N_OUT;

  // Instruction to serial-path decode, used for capture, shift and TDO
  function automatic sbt_pkg::sbt_sel_t path_of(input logic [3:0] op);
    case (op)
      sbt_pkg::OP_EXTEST: path_of = sbt_pkg::SEL_CELL;
      sbt_pkg::OP_SAMPLE: path_of = sbt_pkg::SEL_CELL;
      sbt_pkg::OP_IDENT:  path_of = sbt_pkg::SEL_ID;
      sbt_pkg::OP_HIGHZ:  path_of = sbt_pkg::SEL_BYP;
      sbt_pkg::OP_CLAMP:  path_of = sbt_pkg::SEL_BYP;
      sbt_pkg::OP_BYPASS: path_of = sbt_pkg::SEL_BYP;
      // Reserved codes fall back to bypass so a stray load stays harmless
      default:            path_of = sbt_pkg::SEL_BYP;
    endcase
  endfunction : path_of

  localparam logic [31:0] ID_VALUE = {ID_REV, ID_DEV, ID_MFR, sbt_pkg::ID_PRESENT_BIT};

  // ---------------- Core domain ----------------
  logic [N_IN-1:0] in_s1_q;
  logic [N_IN-1:0] in_s2_q;
  logic [W-1:0]    fifo_data;
  logic            fifo_valid;
  logic            fifo_ready;
  logic [W-1:0]    hold_q;
  logic [W-1:0]    hold_d;
  logic            busy_q;
  logic            busy_d;
  logic            req_q;
  logic            req_d;
  logic            ack_s1_q;
  logic            ack_s2_q;
  logic            ack_tq;

  // Pins cross into the core clock before anything reads them
  always_ff @(posedge clk) begin
    if (srst) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
    end else begin
      in_s1_q <= func_in_pin;
      in_s2_q <= in_s1_q;
    end
  end

  assign func_in_sync = in_s2_q;

  // Snapshots queue up while the test clock is slow or stopped
  sbt_fifo #(
    .WIDTH (W),
    .DEPTH (SNAP_DEPTH)
  ) u_snap_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (core_snap_valid),
    .in_ready  (core_snap_ready),
    .in_data   ({in_s2_q, core_out}),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  assign fifo_ready = !busy_q;

  // Toggle handshake: hold word is stable while a request is open
  always_comb begin
    hold_d = hold_q;
    busy_d = busy_q;
    req_d  = req_q;
    if (busy_q && (ack_s2_q == req_q)) begin
      busy_d = 1'b0;
    end else if (!busy_q && fifo_valid) begin
      hold_d = fifo_data;
      busy_d = 1'b1;
      req_d  = !req_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_q   <= '0;
      busy_q   <= 1'b0;
      req_q    <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      hold_q   <= hold_d;
      busy_q   <= busy_d;
      req_q    <= req_d;
      ack_s1_q <= ack_tq;
      ack_s2_q <= ack_s1_q;
    end
  end

  // ---------------- Test clock domain ----------------
  logic                  por_s1_q;
  logic                  por_s2_q;
  logic                  req_s1_q;
  logic                  req_s2_q;
  logic                  ack_d;
  logic [W-1:0]          snap_q;
  logic [W-1:0]          snap_d;
  sbt_pkg::sbt_state_t   st_q;
  sbt_pkg::sbt_state_t   st_d;
  logic [3:0]            ir_sh_q;
  logic [3:0]            ir_sh_d;
  logic [3:0]            ir_q;
  logic [3:0]            ir_d;
  logic                  byp_q;
  logic                  byp_d;
  logic [31:0]           id_sh_q;
  logic [31:0]           id_sh_d;
  logic [W-1:0]          cell_sh_q;
  logic [W-1:0]          cell_sh_d;
  logic [W-1:0]          cell_up_q;
  logic [W-1:0]          cell_up_d;
  sbt_pkg::sbt_sel_t     sel;
  logic                  tdo_d;
  logic                  tdo_oe_d;

  // Core reset reaches the test domain through two flops
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      por_s1_q <= 1'b1;
      por_s2_q <= 1'b1;
    end else begin
      por_s1_q <= srst;
      por_s2_q <= por_s1_q;
    end
  end

  // Controller next state
  always_comb begin
    case (st_q)
      sbt_pkg::ST_RESET:  st_d = tms ? sbt_pkg::ST_RESET  : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_IDLE:   st_d = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_DR: st_d = tms ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR: st_d = tms ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_SH_DR:  st_d = tms ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_EX1_DR: st_d = tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PAU_DR;
      sbt_pkg::ST_PAU_DR: st_d = tms ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PAU_DR;
      sbt_pkg::ST_EX2_DR: st_d = tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_UPD_DR: st_d = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_IR: st_d = tms ? sbt_pkg::ST_RESET  : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR: st_d = tms ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_SH_IR:  st_d = tms ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_EX1_IR: st_d = tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PAU_IR;
      sbt_pkg::ST_PAU_IR: st_d = tms ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PAU_IR;
      sbt_pkg::ST_EX2_IR: st_d = tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_UPD_IR: st_d = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      default:            st_d = sbt_pkg::ST_RESET;
    endcase
  end

  assign sel = path_of(ir_q);

  // Scan registers and snapshot take-over
  always_comb begin
    ir_sh_d  = ir_sh_q;
    ir_d     = ir_q;
    byp_d    = byp_q;
    id_sh_d  = id_sh_q;
    cell_sh_d = cell_sh_q;
    cell_up_d = cell_up_q;
    snap_d   = snap_q;
    ack_d    = ack_tq;
    if (req_s2_q != ack_tq) begin
      snap_d = hold_q;
      ack_d  = req_s2_q;
    end
    case (st_q)
      sbt_pkg::ST_RESET: begin
        ir_d = sbt_pkg::IR_RESET_VAL;
      end
      sbt_pkg::ST_CAP_IR: begin
        ir_sh_d = sbt_pkg::IR_CAPTURE_VAL;
      end
      sbt_pkg::ST_SH_IR: begin
        ir_sh_d = {tdi, ir_sh_q[3:1]};
      end
      sbt_pkg::ST_UPD_IR: begin
        ir_d = ir_sh_q;
      end
      sbt_pkg::ST_CAP_DR: begin
        byp_d = 1'b0;
        if (sel == sbt_pkg::SEL_ID) begin
          id_sh_d = ID_VALUE;
        end
        if (sel == sbt_pkg::SEL_CELL) begin
          cell_sh_d = snap_q;
        end
      end
      sbt_pkg::ST_SH_DR: begin
        case (sel)
          sbt_pkg::SEL_ID:  id_sh_d  = {tdi, id_sh_q[31:1]};
          sbt_pkg::SEL_CELL: cell_sh_d = {tdi, cell_sh_q[W-1:1]};
          default:          byp_d    = tdi;
        endcase
      end
      sbt_pkg::ST_UPD_DR: begin
        if (sel == sbt_pkg::SEL_CELL) begin
          cell_up_d = cell_sh_q;
        end
      end
      default: begin
      end
    endcase
  end

  // Rising edge of the test clock
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      st_q     <= sbt_pkg::ST_RESET;
      ir_sh_q  <= sbt_pkg::IR_RESET_VAL;
      ir_q     <= sbt_pkg::IR_RESET_VAL;
      byp_q    <= 1'b0;
      id_sh_q  <= '0;
      cell_sh_q <= '0;
      cell_up_q <= '0;
      snap_q    <= '0;
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
      ack_tq    <= 1'b0;
    end else if (por_s2_q) begin
      st_q      <= sbt_pkg::ST_RESET;
      ir_sh_q   <= sbt_pkg::IR_RESET_VAL;
      ir_q      <= sbt_pkg::IR_RESET_VAL;
      byp_q     <= 1'b0;
      id_sh_q   <= '0;
      cell_sh_q <= '0;
      cell_up_q <= '0;
      snap_q    <= '0;
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
      ack_tq    <= 1'b0;
    end else begin
      st_q      <= st_d;
      ir_sh_q   <= ir_sh_d;
      ir_q      <= ir_d;
      byp_q     <= byp_d;
      id_sh_q   <= id_sh_d;
      cell_sh_q <= cell_sh_d;
      cell_up_q <= cell_up_d;
      snap_q   <= snap_d;
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      ack_tq   <= ack_d;
    end
  end

  // Serial output, launched half a period ahead of the controller's sample
  always_comb begin
    tdo_d    = 1'b0;
    tdo_oe_d = 1'b0;
    if (st_q == sbt_pkg::ST_SH_IR) begin
      tdo_d    = ir_sh_q[0];
      tdo_oe_d = 1'b1;
    end else if (st_q == sbt_pkg::ST_SH_DR) begin
      tdo_oe_d = 1'b1;
      case (sel)
        sbt_pkg::SEL_ID:  tdo_d = id_sh_q[0];
        sbt_pkg::SEL_CELL: tdo_d = cell_sh_q[0];
        default:          tdo_d = byp_q;
      endcase
    end
  end

  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= tdo_d;
      tdo_oe <= tdo_oe_d;
    end
  end

  // Pin drive; test port pins are never part of this mux
  always_comb begin
    pin_out = core_out;
    pin_oe  = core_oe;
    case (ir_q)
      sbt_pkg::OP_EXTEST: begin
        pin_out = cell_up_q[N_OUT-1:0];
        pin_oe  = 1'b1;
      end
      sbt_pkg::OP_CLAMP: begin
        pin_out = cell_up_q[N_OUT-1:0];
        pin_oe  = 1'b1;
      end
      sbt_pkg::OP_HIGHZ: begin
        pin_oe = 1'b0;
      end
      default: begin
      end
    endcase
  end

endmodule : sbt_tap
`default_nettype wire

// ==== sbt_tap_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_monitor #(
  parameter int N_IN  = 8,
  parameter int N_OUT = 8
) (
  // Core side
  input wire logic             clk,
  input wire logic             srst,
  input wire logic [N_IN-1:0]  func_in_pin,
  input wire logic [N_IN-1:0]  func_in_sync,
  input wire logic [N_OUT-1:0] core_out,
  input wire logic             core_oe,
  input wire logic [N_OUT-1:0] pin_out,
  input wire logic             pin_oe,
  input wire logic             core_snap_ready,
  // Test port
  input wire logic             tck,
  input wire logic             tms,
  input wire logic             trst_n,
  input wire logic             tdo,
  input wire logic             tdo_oe
);
  a_sync_clear: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> func_in_sync == '0) else $error("input copy not cleared");
  a_ready_reset: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> core_snap_ready) else $error("snapshot ready low after reset");
  a_sync_delay: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !$past(srst, 2) |-> func_in_sync == $past(func_in_pin, 2))
    else $error("input copy not two cycles behind pins");
  a_trst_pins: assert property (@(posedge clk) disable iff (srst)
    !trst_n |-> pin_oe == core_oe && pin_out == core_out) else $error("pins forced in test reset");
  a_trst_quiet: assert property (@(posedge clk) disable iff (srst)
    !trst_n |-> !tdo_oe && !tdo) else $error("serial out active in test reset");
  a_tdo_idle: assert property (@(posedge tck) disable iff (!trst_n)
    !tdo_oe |-> !tdo) else $error("serial out not low while idle");
  a_shift_exit: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe && tms |=> !tdo_oe) else $error("shift not left on mode select");
  a_shift_hold: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe && !tms |=> tdo_oe) else $error("shift left without mode select");
  a_shift_enter: assert property (@(posedge tck) disable iff (!trst_n)
    !tdo_oe && tms |=> !tdo_oe) else $error("shift entered on mode select high");
  a_id_first: assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] ##1 !tms ##1 tms ##1 !tms ##1 !tms |=> tdo_oe && tdo)
    else $error("identity bit zero not first after reset");
endmodule : sbt_tap_monitor

bind sbt_tap sbt_tap_monitor #(.N_IN(N_IN), .N_OUT(N_OUT)) u_mon (
  .clk, .srst, .func_in_pin, .func_in_sync, .core_out, .core_oe, .pin_out, .pin_oe,
  .core_snap_ready, .tck, .tms, .trst_n, .tdo, .tdo_oe);
`default_nettype wire

// ==== sbt_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbt_ctl_model (
  // Test port
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  output var logic trst_n,
  input wire logic tdo
);
  // One fixed test clock rate; clock stands still between calls
  localparam realtime HALF = 3.0;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
  end

  task automatic cyc(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #HALF tck = 1'b1;
    o = tdo;
    #HALF tck = 1'b0;
  endtask : cyc

  // Data line toggles outside shift so stale bits never look valid
  task automatic step(input logic m);
    logic o;
    cyc(m, ~tdi, o);
  endtask : step

  task automatic idle(input int n);
    repeat (n) step(1'b0);
  endtask : idle

  task automatic pulse_reset();
    trst_n = 1'b0;
    #HALF trst_n = 1'b1;
    repeat (5) step(1'b1);
    step(1'b0);
  endtask : pulse_reset

  // From idle: one scan of n bits, LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1);
    if (ir) begin
      step(1'b1);
    end
    step(1'b0);
    step(1'b0);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1);
    step(1'b0);
  endtask : scan
endmodule : sbt_ctl_model
`default_nettype wire

// ==== sbt_tap_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_tb_top;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] oe;
    logic [5:0] len;
  } sbt_row_t;

  localparam logic [31:0] PAT = 32'hC3A5_5A3C;
  localparam logic [31:0] ID_VAL = {sbt_pkg::ID_REV_DEFAULT, sbt_pkg::ID_DEV_DEFAULT,
                                    sbt_pkg::ID_MFR_DEFAULT, 1'b1};

  logic       clk, srst, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [7:0] func_in_pin, func_in_sync, core_out, pin_out;
  logic       core_oe, pin_oe, core_snap_valid, core_snap_ready;
  logic [31:0] dout;
  int         num_errors, checked, n;

  // Pin kind: 0 normal, 1 boundary cells forced, 2 drivers off; defined opcodes only
  sbt_row_t rows [10] = '{
    '{4'h1, 2'h0, 6'h10}, '{4'h0, 2'h1, 6'h10}, '{4'h8, 2'h1, 6'h01}, '{4'h3, 2'h2, 6'h01},
    '{4'h2, 2'h0, 6'h20}, '{4'hF, 2'h0, 6'h01}, '{4'h0, 2'h1, 6'h10}, '{4'h3, 2'h2, 6'h01},
    '{4'hD, 2'h0, 6'h01}, '{4'h8, 2'h1, 6'h01}};

  sbt_tap u_dut (.clk, .srst, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .func_in_pin, .func_in_sync,
    .core_out, .core_oe, .pin_out, .pin_oe, .core_snap_valid, .core_snap_ready);
  sbt_ctl_model u_ctl (.tck, .tms, .tdi, .trst_n, .tdo);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Whole run needs well under 20 us
  initial begin
    #50000;
    num_errors++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    core_oe = 1'b1;
    core_out = 8'h3C;
    func_in_pin = 8'h96;
    core_snap_valid = 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    u_ctl.pulse_reset();
    u_ctl.scan(1'b0, 32, PAT, dout);
    check("identity after reset", dout, ID_VAL);
    $display("reset test done");

    foreach (rows[i]) begin
      u_ctl.scan(1'b1, 4, {28'h0, rows[i].op}, dout);
      check("ir capture", dout, 32'h0000_000D);
      u_ctl.scan(1'b0, 32, PAT, dout);
      check("path length", dout >> rows[i].len, PAT & (32'hFFFF_FFFF >> rows[i].len));
      if (rows[i].len == 6'h01) begin
        check("bypass capture", 32'(dout[0]), 32'h0);
      end
      if (rows[i].op == 4'h2) begin
        check("identity", dout, ID_VAL);
      end
      check("pin oe", 32'(pin_oe), 32'(rows[i].oe == 2'h1 || (rows[i].oe == 2'h0 && core_oe)));
      if (rows[i].oe != 2'h2) begin
        check("pin out", 32'(pin_out), 32'(rows[i].oe == 2'h1 ? PAT[23:16] : core_out));
      end
      $display("row %0d opcode %h done", i, rows[i].op);
    end

    // Test clock stopped: crossing stalls, one word parks past the buffer
    @(posedge clk);
    core_snap_valid <= 1'b1;
    n = 0;
    while (n < 40) begin
      @(negedge clk);
      if (core_snap_ready !== 1'b1) begin
        break;
      end
      n++;
    end
    @(posedge clk);
    core_snap_valid <= 1'b0;
    check("words until full", 32'(n), 32'(sbt_pkg::SNAP_DEPTH + 1));
    u_ctl.idle(200);
    check("ready after drain", 32'(core_snap_ready), 32'h1);
    $display("snapshot test done");

    u_ctl.scan(1'b1, 4, 32'h1, dout);
    u_ctl.scan(1'b0, 32, PAT, dout);
    check("sample capture", 32'(dout[15:0]), 32'h0000_963C);
    $display("sample test done");

    // Core enable low so forcing and release are both visible
    @(posedge clk);
    core_oe <= 1'b0;
    u_ctl.scan(1'b1, 4, 32'h0, dout);
    check("forced oe", 32'(pin_oe), 32'h1);
    // Core reset alone brings the test logic back while the test clock runs
    @(posedge clk);
    srst <= 1'b1;
    u_ctl.idle(4);
    @(posedge clk);
    srst <= 1'b0;
    u_ctl.idle(3);
    check("oe after core reset", 32'(pin_oe), 32'(core_oe));
    $display("core reset test done");
    u_ctl.scan(1'b1, 4, 32'h0, dout);
    check("forced oe again", 32'(pin_oe), 32'h1);
    u_ctl.pulse_reset();
    check("oe after test reset", 32'(pin_oe), 32'(core_oe));
    u_ctl.scan(1'b0, 32, PAT, dout);
    check("identity after test reset", dout, ID_VAL);
    $display("second reset test done");
    give_verdict();
  end
endmodule : sbt_tap_tb_top
`default_nettype wire
